// file: design/asp_slot_port.sv
// Behaviour
// - Chain bit 0 means shared bus; 1 means daisy chain, idle primary cycles pass upstream data.
// - Bus error detection runs when the detect-disable bit is 0.
// - Line bit 0 sends the channel on primary output, 1 on secondary.
// - In TDM a channel sits in the slot equal to its 6-bit index.
// - In I2S/LJ indices 0-31 are left slots, 32-63 right slots.
// - Reset: channel 1 slot 0, channel 2 slot 1, both on primary.
// - Channel 1 map lives at 0x0B, bit 7 reserved reading zero.
// - Format code 0 TDM, 1 I2S, 2 LJ, 3 reserved.
// - Word length code 0..3 gives 16, 20, 24, 32 bits; reset 32.
// - Unused cycles drive low when fill is 0, float when fill is 1.
`timescale 1ns/100ps
module asp_slot_port (
   input wire logic clock, // 125 MHz system clock
   input wire logic rst, // Asynchronous, active high
   input wire logic ce, // Freezes all state while low
   input wire asp_pkg::asp_reg_req_type reg_req, // Register access
   output logic [7:0] reg_rdata_ff, // Read data, valid cycle after rd
   input wire logic bclk, // Bit clock from host
   input wire logic fsync, // Frame sync from host
   input wire logic daisy_in, // Data from upstream device
   input wire logic in_valid, // Sample pair offered
   input wire asp_pkg::asp_pair_type in_data, // Sample pair, MSB aligned
   output logic in_ready_ff, // Buffer has room
   output logic primary_serial_out_ff, // Primary data out
   output logic primary_serial_oe_ff, // Primary drive enable
   output logic general_io_pin_one_ff, // Secondary data out
   output logic general_io_pin_one_oe_ff, // Secondary drive enable
   output logic fault_active_ff, // Bus fault being recovered
   output logic halted_ff // Waiting for host configuration
);
   import asp_pkg::*;

   // ==========================================================
   // Registers
   logic [7:0] cfg0_ff, cfg2_ff, ch1_ff, ch2_ff;
   logic [7:0] nxt_cfg0, nxt_cfg2, nxt_ch1, nxt_ch2, nxt_rdata;
   logic cfg_write;

   // Decode writes and reads; any mapped write counts as reconfiguration
   always_comb begin
      nxt_cfg0 = cfg0_ff;
      nxt_cfg2 = cfg2_ff;
      nxt_ch1 = ch1_ff;
      nxt_ch2 = ch2_ff;
      nxt_rdata = reg_rdata_ff;
      cfg_write = 1'b0;
      if (reg_req.wr) begin
         cfg_write = 1'b1;
         case (reg_req.addr)
            ADDR_CFG0: nxt_cfg0 = reg_req.wdata;
            ADDR_CFG2: nxt_cfg2 = reg_req.wdata & MASK_CFG2;
            ADDR_CH1: nxt_ch1 = reg_req.wdata & MASK_CH;
            ADDR_CH2: nxt_ch2 = reg_req.wdata & MASK_CH;
            default: cfg_write = 1'b0;
         endcase
      end
      if (reg_req.rd) begin
         case (reg_req.addr)
            ADDR_CFG0: nxt_rdata = cfg0_ff;
            ADDR_CFG2: nxt_rdata = cfg2_ff;
            ADDR_CH1: nxt_rdata = ch1_ff;
            ADDR_CH2: nxt_rdata = ch2_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   // Register storage with documented defaults
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg0_ff <= RST_CFG0;
         cfg2_ff <= RST_CFG2;
         ch1_ff <= RST_CH1;
         ch2_ff <= RST_CH2;
         reg_rdata_ff <= 8'h00;
      end else if (ce) begin
         cfg0_ff <= nxt_cfg0;
         cfg2_ff <= nxt_cfg2;
         ch1_ff <= nxt_ch1;
         ch2_ff <= nxt_ch2;
         reg_rdata_ff <= nxt_rdata;
      end
   end

   // ==========================================================
   // Pin synchronisers: bit 0 bit clock, 1 frame sync, 2 daisy
   logic [2:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
   logic [2:0] nxt_s1, nxt_s2, nxt_s3;

   // Stage one feeds stage two only; edges use stages two and three
   always_comb begin
      nxt_s1 = {daisy_in, fsync, bclk};
      nxt_s2 = pin_s1_ff;
      nxt_s3 = pin_s2_ff;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_s1_ff <= 3'h0;
         pin_s2_ff <= 3'h0;
         pin_s3_ff <= 3'h0;
      end else if (ce) begin
         pin_s1_ff <= nxt_s1;
         pin_s2_ff <= nxt_s2;
         pin_s3_ff <= nxt_s3;
      end
   end

   // ==========================================================
   // Two-entry sample buffer, drained one pair per frame
   asp_pair_type mem_ff [2];
   asp_pair_type nxt_mem [2];
   logic wp_ff, rp_ff, nxt_wp, nxt_rp, push, pop, nxt_ready;
   logic [1:0] fcnt_ff, nxt_fcnt;

   always_comb begin
      push = in_valid && in_ready_ff;
      nxt_mem = mem_ff;
      if (push) begin
         nxt_mem[wp_ff] = in_data;
      end
      nxt_wp = wp_ff ^ push;
      nxt_rp = rp_ff ^ pop;
      nxt_fcnt = 2'(fcnt_ff + {1'b0, push} - {1'b0, pop});
      // Ready follows the next fill level so a full buffer stalls the source
      nxt_ready = nxt_fcnt != FIFO_DEPTH;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mem_ff[0] <= '0;
         mem_ff[1] <= '0;
         wp_ff <= 1'b0;
         rp_ff <= 1'b0;
         fcnt_ff <= 2'h0;
         in_ready_ff <= 1'b0;
      end else if (ce) begin
         mem_ff <= nxt_mem;
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         fcnt_ff <= nxt_fcnt;
         in_ready_ff <= nxt_ready;
      end
   end

   // ==========================================================
   // Frame timing, fault recovery and serial output
   asp_state_type state_ff, nxt_state;
   asp_pair_type cur_ff, nxt_cur;
   asp_bit_type b1, b2;
   logic [11:0] cnt_ff, len_ff, nxt_cnt, nxt_len, nlen, st1, st2;
   logic [1:0] good_ff, nxt_good, fmt;
   logic [5:0] w;
   logic fs_smp_ff, nxt_fs_smp, rise, fall, fs, dz, fedge, err_now, fmt_ok, run;
   logic p_act, p_bit, s_act, s_bit, l1, l2;
   logic nxt_pout, nxt_poe, nxt_sout, nxt_soe;

   always_comb begin
      fmt = cfg0_ff[POS_FMT +: 2];
      w = wbits(cfg0_ff[POS_WLEN +: 2]);
      fmt_ok = fmt != 2'h3;
      run = state_ff == ST_RUN;
      l1 = ch1_ff[POS_LINE];
      l2 = ch2_ff[POS_LINE];
      rise = pin_s2_ff[0] & ~pin_s3_ff[0];
      fall = ~pin_s2_ff[0] & pin_s3_ff[0];
      fs = pin_s2_ff[1];
      dz = pin_s2_ff[2];
      // I2S frames open on the falling sync, TDM and LJ on the rising one
      fedge = rise && ((fmt == FMT_I2S) ? (fs_smp_ff & ~fs) : (~fs_smp_ff & fs));
      nlen = cnt_ff + 12'h001;
      // Error: frame length changed, or sync missing for a whole count span
      err_now = !cfg2_ff[POS_ERRDIS] && rise && (fedge ? (len_ff != 12'h000 && nlen != len_ff)
                : (cnt_ff == CNT_MAX - 12'h001));
      pop = fedge && run && fcnt_ff != 2'h0;
      nxt_fs_smp = rise ? fs : fs_smp_ff;
      nxt_cnt = cnt_ff;
      nxt_len = len_ff;
      nxt_cur = cur_ff;
      if (fedge) begin
         nxt_cnt = 12'h000;
         nxt_len = nlen;
         nxt_cur = pop ? mem_ff[rp_ff] : '0; // Silence when starved
      end else if (rise) begin
         if (cnt_ff != CNT_MAX) begin
            nxt_cnt = nlen;
         end else begin
            nxt_len = 12'h000; // Lost sync: next frame is not compared
         end
      end
      nxt_state = state_ff;
      nxt_good = good_ff;
      unique case (state_ff)
         ST_RUN: begin
            if (err_now) begin
               nxt_state = ST_FAULT;
               nxt_good = 2'h0;
            end
         end
         ST_FAULT: begin
            if (err_now) begin
               nxt_good = 2'h0;
            end else if (fedge && len_ff != 12'h000) begin
               if (good_ff == GOOD_FRAMES - 2'h1) begin
                  nxt_state = cfg2_ff[POS_RCOVDIS] ? ST_HALT : ST_RUN;
               end else begin
                  nxt_good = good_ff + 2'h1;
               end
            end
         end
         ST_HALT: begin
            if (cfg_write) begin
               nxt_state = ST_RUN;
            end
         end
      endcase
      st1 = slot_start(ch1_ff[5:0], fmt, w, {1'b0, len_ff[11:1]});
      st2 = slot_start(ch2_ff[5:0], fmt, w, {1'b0, len_ff[11:1]});
      b1 = pick(cnt_ff, st1, len_ff, w, cur_ff.ch1);
      b2 = pick(cnt_ff, st2, len_ff, w, cur_ff.ch2);
      // Channel 1 wins if both are mapped onto the same bits of one line
      p_act = (b1.act && !l1) || (b2.act && !l2);
      p_bit = (b1.act && !l1) ? b1.bit_v : b2.bit_v;
      s_act = (b1.act && l1) || (b2.act && l2);
      s_bit = (b1.act && l1) ? b1.bit_v : b2.bit_v;
      nxt_pout = primary_serial_out_ff;
      nxt_poe = primary_serial_oe_ff;
      nxt_sout = general_io_pin_one_ff;
      nxt_soe = general_io_pin_one_oe_ff;
      // Data changes on the falling bit clock so the host samples on rising
      if (fall) begin
         if (!run || !fmt_ok) begin
            nxt_pout = 1'b0;
            nxt_poe = 1'b0;
            nxt_sout = 1'b0;
            nxt_soe = 1'b0;
         end else begin
            if (p_act) begin
               nxt_pout = p_bit;
               nxt_poe = 1'b1;
            end else if (cfg2_ff[POS_DAISY]) begin
               nxt_pout = dz;
               nxt_poe = 1'b1;
            end else begin
               nxt_pout = 1'b0;
               nxt_poe = !cfg0_ff[POS_FILL];
            end
            nxt_sout = s_act ? s_bit : 1'b0;
            nxt_soe = s_act || !cfg0_ff[POS_FILL];
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= ST_RUN;
         cur_ff <= '0;
         cnt_ff <= 12'h000;
         len_ff <= 12'h000;
         good_ff <= 2'h0;
         fs_smp_ff <= 1'b0;
         primary_serial_out_ff <= 1'b0;
         primary_serial_oe_ff <= 1'b0;
         general_io_pin_one_ff <= 1'b0;
         general_io_pin_one_oe_ff <= 1'b0;
         fault_active_ff <= 1'b0;
         halted_ff <= 1'b0;
      end else if (ce) begin
         state_ff <= nxt_state;
         cur_ff <= nxt_cur;
         cnt_ff <= nxt_cnt;
         len_ff <= nxt_len;
         good_ff <= nxt_good;
         fs_smp_ff <= nxt_fs_smp;
         primary_serial_out_ff <= nxt_pout;
         primary_serial_oe_ff <= nxt_poe;
         general_io_pin_one_ff <= nxt_sout;
         general_io_pin_one_oe_ff <= nxt_soe;
         fault_active_ff <= nxt_state == ST_FAULT;
         halted_ff <= nxt_state == ST_HALT;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   a_reset_slot_map: assert property ($fell(rst) |-> ch1_ff == 8'h00 && ch2_ff == 8'h01)
      else $error("slot map reset values wrong");
   a_ch1_write_mask: assert property (ce && reg_req.wr && reg_req.addr == ADDR_CH1
      |=> ch1_ff == ($past(reg_req.wdata) & 8'h7F))
      else $error("channel 1 map write not stored");
   a_error_enters_fault: assert property (ce && err_now && run |=> state_ff == ST_FAULT)
      else $error("bus error did not enter fault");
   a_error_masked: assert property (ce && run && cfg2_ff[POS_ERRDIS]
      |=> !fault_active_ff)
      else $error("fault raised while detection off");
   a_halt_holds: assert property (ce && state_ff == ST_HALT && !cfg_write
      |=> state_ff == ST_HALT)
      else $error("left halt without configuration");
   a_auto_resume: assert property (ce && state_ff == ST_FAULT && !err_now && fedge
      && len_ff != 12'h000 && good_ff == 2'h1 && !cfg2_ff[POS_RCOVDIS]
      |=> state_ff == ST_RUN)
      else $error("no auto resume after recovery");
   a_line_secondary: assert property (ce && fall && run && fmt_ok && b1.act && l1
      |=> general_io_pin_one_ff == $past(b1.bit_v) && general_io_pin_one_oe_ff)
      else $error("channel 1 not on secondary line");
   a_tdm_msb_first: assert property (ce && fall && run && fmt == FMT_TDM && b1.act
      && !l1 && cnt_ff == st1 |=> primary_serial_out_ff == $past(cur_ff.ch1[31]))
      else $error("TDM slot did not open with MSB");
   a_right_half: assert property (fmt_ok && fmt != FMT_TDM && ch1_ff[5]
      |-> st1 >= {1'b0, len_ff[11:1]})
      else $error("right slot placed in left half");
   a_fill_level: assert property (ce && fall && run && fmt_ok && !p_act
      && !cfg2_ff[POS_DAISY] |=> !primary_serial_out_ff
      && primary_serial_oe_ff == !$past(cfg0_ff[POS_FILL]))
      else $error("idle cycle fill wrong");
   a_chain_pass: assert property (ce && fall && run && fmt_ok && !p_act
      && cfg2_ff[POS_DAISY] |=> primary_serial_out_ff == $past(dz) && primary_serial_oe_ff)
      else $error("daisy data not passed");
   a_outside_quiet: assert property (b1.act |-> st1 + {6'h00, w} <= len_ff)
      else $error("slot past frame end sent");
   a_reserved_format: assert property (ce && fall && fmt == 2'h3
      |=> !primary_serial_oe_ff && !general_io_pin_one_oe_ff)
      else $error("reserved format drove pins");

   c_fault_recovered: cover property (state_ff == ST_FAULT ##1 state_ff == ST_RUN);
   c_halt_entered: cover property (state_ff == ST_FAULT ##1 state_ff == ST_HALT);
   c_tdm_ch1_sent: cover property (fall && run && fmt == FMT_TDM && b1.act);
   c_i2s_right: cover property (fall && run && fmt == FMT_I2S && b2.act && ch2_ff[5]);
endmodule

// file: inc/asp_pkg.sv
package asp_pkg;
   // ==========================================================
   // Register map, page 0
   localparam logic [7:0] ADDR_CFG0 = 8'h07;
   localparam logic [7:0] ADDR_CFG2 = 8'h09;
   localparam logic [7:0] ADDR_CH1 = 8'h0B;
   localparam logic [7:0] ADDR_CH2 = 8'h0C;
   localparam logic [7:0] RST_CFG0 = 8'h30;
   localparam logic [7:0] RST_CFG2 = 8'h00;
   localparam logic [7:0] RST_CH1 = 8'h00;
   localparam logic [7:0] RST_CH2 = 8'h01;
   localparam logic [7:0] MASK_CFG2 = 8'hB0; // Reserved bits read zero
   localparam logic [7:0] MASK_CH = 8'h7F;
   // ==========================================================
   // Field positions
   localparam int POS_FMT = 6;
   localparam int POS_WLEN = 4;
   localparam int POS_FILL = 0;
   localparam int POS_DAISY = 7;
   localparam int POS_ERRDIS = 5;
   localparam int POS_RCOVDIS = 4;
   localparam int POS_LINE = 6;
   // ==========================================================
   // Codes and counts
   localparam logic [1:0] FMT_TDM = 2'h0;
   localparam logic [1:0] FMT_I2S = 2'h1;
   localparam logic [1:0] FMT_LJ = 2'h2;
   localparam logic [11:0] CNT_MAX = 12'hFFF;
   localparam logic [1:0] GOOD_FRAMES = 2'h2;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
   // ==========================================================
   // Types
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } asp_reg_req_type;
   typedef struct packed {
      logic [31:0] ch1;
      logic [31:0] ch2;
   } asp_pair_type;
   typedef struct packed {
      logic act;
      logic bit_v;
   } asp_bit_type;
   typedef enum logic [1:0] {ST_RUN, ST_FAULT, ST_HALT} asp_state_type;
   // ==========================================================
   // Slot placement helpers; slot_start and pick used once per channel, wbits once
   function automatic logic [5:0] wbits(input logic [1:0] c);
      case (c)
         2'h0: wbits = 6'h10;
         2'h1: wbits = 6'h14;
         2'h2: wbits = 6'h18;
         default: wbits = 6'h20;
      endcase
   endfunction

   function automatic logic [11:0] slot_start(input logic [5:0] idx, input logic [1:0] fmt,
                                              input logic [5:0] w, input logic [11:0] half);
      logic [11:0] base;
      base = 12'h000;
      if (fmt == FMT_TDM) begin
         base = {6'h00, idx} * {6'h00, w};
      end else begin
         // Upper index bit picks the right half of the frame
         base = (idx[5] ? half : 12'h000) + {7'h00, idx[4:0]} * {6'h00, w};
         base = base + {11'h000, fmt == FMT_I2S}; // I2S data lags sync by one bit
      end
      slot_start = base;
   endfunction

   function automatic asp_bit_type pick(input logic [11:0] cnt, input logic [11:0] start,
                                        input logic [11:0] len, input logic [5:0] w,
                                        input logic [31:0] s);
      logic [11:0] off;
      logic [11:0] stop;
      off = cnt - start;
      stop = start + {6'h00, w};
      // A slot that would cross the frame end is dropped whole
      pick.act = (cnt >= start) && (cnt < stop) && (stop <= len) && (stop > start);
      pick.bit_v = s[5'h1F - off[4:0]];
   endfunction
endpackage

// file: tb/asp_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// Host side: makes bit clock and frame sync, captures both data lines
module asp_host_model (
   input wire logic run, // Start frames, stops at a frame end
   input wire logic [1:0] fmt, // Framing: 0 TDM, 1 I2S, 2 LJ
   input wire logic [7:0] len, // Bits per frame, read at frame start
   input wire logic pri_out, // Primary data
   input wire logic pri_oe, // Primary drive enable
   input wire logic sec_out, // Secondary data
   input wire logic sec_oe, // Secondary drive enable
   output logic bclk, // Bit clock, still between runs
   output logic fsync, // Frame sync
   output logic [255:0] pri_q, // Last whole frame, primary
   output logic [255:0] sec_q, // Last whole frame, secondary
   output int frames // Whole frames captured
);
   logic [255:0] cur_p;
   logic [255:0] cur_s;
   logic have;
   int cl;
   int pl;
   // A released line is recorded as floating, never as its last value
   function automatic logic pin(input logic oe, input logic d);
      return oe ? d : 1'bz;
   endfunction
   initial begin
      bclk = 1'b0;
      fsync = 1'b0;
      pri_q = '0;
      sec_q = '0;
      cur_p = '0;
      cur_s = '0;
      frames = 0;
      have = 1'b0;
      pl = 0;
   end
   // Frame loop; sync changes only while the clock is low so each rise sees it settled
   always begin
      if (!run) begin
         have = 1'b0;
         #8;
      end else begin
         cl = len;
         for (int i = 0; i < cl; i++) begin
            fsync = (fmt == 2'h1) ? (i >= cl / 2) : (fmt == 2'h2) ? (i < cl / 2) : (i == 0);
            #62.5;
            bclk = 1'b1;
            // Each rise takes the bit launched after the previous fall
            if (i > 0) begin
               cur_p[i-1] = pin(pri_oe, pri_out);
               cur_s[i-1] = pin(sec_oe, sec_out);
            end else if (have) begin
               cur_p[pl-1] = pin(pri_oe, pri_out);
               cur_s[pl-1] = pin(sec_oe, sec_out);
               pri_q = cur_p;
               sec_q = cur_s;
               frames++;
            end
            #62.5;
            bclk = 1'b0;
         end
         have = 1'b1;
         pl = cl;
      end
   end
endmodule

// file: tb/asp_slot_port_tb.sv
`timescale 1ns/100ps
// ==========================================================
// Bench: register map, sample buffer, slot placement and fault handling
module asp_slot_port_tb;
   import asp_pkg::*;
   logic clock = 1'b0, rst = 1'b1, ce = 1'b1, in_valid = 1'b0, daisy_in = 1'b0, run = 1'b0;
   logic bclk, fsync, in_ready, p_out, p_oe, s_out, s_oe, fault, halted, fill, dsy;
   logic [7:0] rdata, c1, c2, len = 8'h40;
   logic [1:0] hfmt = 2'h0, fmt, wl;
   logic [255:0] pq, sq, exp_p, exp_s;
   asp_reg_req_type reg_req = '0;
   asp_pair_type in_data = '0, pr;
   int frames, acc, mismatches = 0, n_checks = 0;
   always #4 clock = ~clock;
   asp_slot_port dut_u (.clock(clock), .rst(rst), .ce(ce), .reg_req(reg_req),
      .reg_rdata_ff(rdata), .bclk(bclk), .fsync(fsync), .daisy_in(daisy_in),
      .in_valid(in_valid), .in_data(in_data), .in_ready_ff(in_ready),
      .primary_serial_out_ff(p_out), .primary_serial_oe_ff(p_oe),
      .general_io_pin_one_ff(s_out), .general_io_pin_one_oe_ff(s_oe),
      .fault_active_ff(fault), .halted_ff(halted));
   asp_host_model host_u (.run(run), .fmt(hfmt), .len(len), .pri_out(p_out), .pri_oe(p_oe),
      .sec_out(s_out), .sec_oe(s_oe), .bclk(bclk), .fsync(fsync), .pri_q(pq), .sec_q(sq),
      .frames(frames));
   // ==========================================================
   // Shared checks, bus cycles and waits
   task automatic chk(input string what, input logic [255:0] e, input logic [255:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask
   task tally_and_finish;
      if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clock);
      reg_req = '0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clock);
      reg_req = '0;
      chk("register", 256'(e), 256'(rdata));
   endtask
   // Bounded waits; running out counts a mismatch, and in wait_frames also ends the run
   task automatic wait_frames(input int n);
      int f0;
      f0 = frames;
      for (int i = 0; i < n * 2000 && frames < f0 + n; i++) @(negedge clock);
      if (frames < f0 + n) begin
         mismatches++;
         tally_and_finish;
      end
   endtask
   task automatic wait_flag(input int sel, input logic v, input int lim);
      int i;
      for (i = 0; i < lim && ((sel == 0) ? fault : halted) !== v; i++) @(negedge clock);
      chk(sel == 0 ? "fault flag" : "halt flag", 256'(v), 256'(sel == 0 ? fault : halted));
   endtask
   // ==========================================================
   // Reference placement: slot start from index and word length, ch1 written last wins
   task automatic place(input logic [7:0] c, input logic [31:0] d);
      int w, st;
      w = (wl == 2'h3) ? 32 : 16 + 4 * wl;
      st = (fmt == FMT_TDM) ? c[5:0] * w : (c[5] ? 32 : 0) + c[4:0] * w + (fmt == FMT_I2S);
      if (st + w <= 64) for (int k = 0; k < w; k++) begin
         if (c[6]) exp_s[st+k] = d[31-k];
         else exp_p[st+k] = d[31-k];
      end
   endtask
   task automatic build;
      exp_p = '0;
      exp_s = '0;
      for (int i = 0; i < 64; i++) begin
         exp_p[i] = (fmt == 2'h3) ? 1'bz : dsy ? daisy_in : fill ? 1'bz : 1'b0;
         exp_s[i] = (fmt == 2'h3 || fill) ? 1'bz : 1'b0;
      end
      if (fmt != 2'h3) begin
         place(c2, pr.ch2);
         place(c1, pr.ch1);
      end
   endtask
   // Watchdog against a hang anywhere
   initial begin
      #780000;
      mismatches++;
      tally_and_finish;
   end
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(45510));
      repeat (8) @(negedge clock);
      chk("primary enable in reset", 256'h0, 256'(p_oe));
      rst = 1'b0;
      rd_chk(ADDR_CFG0, 8'h30);
      rd_chk(ADDR_CFG2, 8'h00);
      rd_chk(ADDR_CH1, 8'h00);
      rd_chk(ADDR_CH2, 8'h01);
      rd_chk(8'h20, 8'h00);
      // Clock enable low: a write offered then is not taken
      ce = 1'b0;
      wr(ADDR_CH1, 8'h55);
      ce = 1'b1;
      rd_chk(ADDR_CH1, 8'h00);
      wr(ADDR_CH1, 8'hFF);
      rd_chk(ADDR_CH1, 8'h7F);
      wr(ADDR_CFG2, 8'hFF);
      rd_chk(ADDR_CFG2, 8'hB0);
      wr(ADDR_CFG2, 8'h00);
      wr(ADDR_CH1, 8'h00);
      // Bit clock stands still: the buffer takes two pairs and refuses the rest
      pr = {$urandom, $urandom};
      in_data = pr;
      in_valid = 1'b1;
      acc = 0;
      // Count ready as it stands before each edge, where a push is decided
      repeat (6) begin
         acc += in_ready;
         @(negedge clock);
      end
      chk("pairs accepted", 256'd2, 256'(acc));
      run = 1'b1;
      // Every format, word length, fill and chain mode; random slots, lines and data
      for (int k = 0; k < 8; k++) begin
         @(negedge clock);
         fmt = 2'(k % 4);
         wl = 2'((k + k / 4) % 4);
         fill = (k >= 4);
         dsy = (k % 3 == 2);
         c1 = (k == 0) ? 8'h00 : {1'b0, 1'($urandom % 2), 6'($urandom % ((k % 2) ? 64 : 4))};
         c2 = (k == 0) ? 8'h01 : {1'b0, 1'($urandom % 2), 6'($urandom % ((k % 2) ? 64 : 4))};
         daisy_in = 1'($urandom % 2);
         pr = {$urandom, $urandom};
         in_data = pr;
         hfmt = (fmt == 2'h3) ? 2'h0 : fmt;
         wr(ADDR_CFG0, {fmt, wl, 3'h0, fill});
         wr(ADDR_CFG2, {dsy, 7'h00});
         if (k != 0) wr(ADDR_CH1, c1);
         if (k != 0) wr(ADDR_CH2, c2);
         wait_frames(7);
         build;
         chk("fault flag", 256'h0, 256'(fault));
         chk("primary frame", exp_p, pq);
         chk("secondary frame", exp_s, sq);
      end
      // Detection off: a length change raises nothing
      wr(ADDR_CFG0, 8'h30);
      hfmt = 2'h0;
      wr(ADDR_CFG2, 8'h30);
      wait_frames(2);
      len = 8'd48;
      acc = 0;
      repeat (3000) begin
         @(negedge clock);
         acc += fault;
      end
      chk("fault cycles", 256'h0, 256'(acc));
      // Detection on, no auto resume: fault, then halt until a register write
      wr(ADDR_CFG2, 8'h10);
      len = 8'd64;
      wait_flag(0, 1'b1, 3000);
      wait_flag(1, 1'b1, 5000);
      wait_frames(1);
      chk("primary enable halted", 256'h0, 256'(p_oe));
      wr(ADDR_CH1, 8'h00);
      wait_flag(1, 1'b0, 8);
      // Auto resume: the fault clears by itself
      wr(ADDR_CFG2, 8'h00);
      len = 8'd48;
      wait_flag(0, 1'b1, 3000);
      wait_flag(0, 1'b0, 5000);
      chk("halt after resume", 256'h0, 256'(halted));
      tally_and_finish;
   end
endmodule
